// ### verilog/cssa_defines.svh
// Constants for the signed sum slice: opcodes, widths, timing
`ifndef CSSA_DEFINES_SVH
`define CSSA_DEFINES_SVH
`define CSSA_W 32
`define CSSA_OPW 6
`define CSSA_OP_MAGSUB 6'h23
`define CSSA_OP_CARRY_STEERED_ACCUMULATE 6'h24
`define CSSA_OP_INVERSE_CARRY_STEERED_ACCUMULATE 6'h25
`define CSSA_OP_ZERO_STEERED_ACCUMULATE 6'h26
`define CSSA_OP_INVERSE_ZERO_STEERED_ACCUMULATE 6'h27
`define CSSA_CYCLES 4
`define CSSA_CNT_W 2
`define CSSA_CNT_LAST 2'h2
`define CSSA_CNT_ZERO 2'h0
`define CSSA_ZERO32 32'h00000000
`endif

// ### verilog/cssa_pkg.sv
// Types for the signed sum slice
`include "cssa_defines.svh"
package cssa_pkg;
    typedef logic [`CSSA_W-1:0] cssa_word_t;
    typedef logic [`CSSA_OPW-1:0] cssa_op_t;
    typedef enum logic [1:0] {
        CSSA_IDLE,
        CSSA_BUSY
    } cssa_state_t;
endpackage : cssa_pkg

// ### verilog/cssa_alu.sv
// Arithmetic slice: magnitude subtract and flag-steered sums
`include "cssa_defines.svh"
module cssa_alu (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire cssa_pkg::cssa_op_t opcode,
    input wire cssa_pkg::cssa_word_t dest_in,
    input wire cssa_pkg::cssa_word_t src_in,
    input wire logic zero_in,
    input wire logic carry_in,
    input wire logic wr_result,
    input wire logic wr_zero,
    input wire logic wr_carry,
    output logic busy,
    output logic done,
    output logic result_we,
    output cssa_pkg::cssa_word_t result,
    output logic zero_we,
    output logic zero_out,
    output logic carry_we,
    output logic carry_out
);
    import cssa_pkg::*;

    cssa_state_t state_q, state_d;
    logic [`CSSA_CNT_W-1:0] cnt_q;
    cssa_op_t op_q;
    cssa_word_t d_q, s_q;
    logic z_q, c_q, wr_q, wz_q, wc_q;
    logic valid_op_q;

    function automatic cssa_word_t negate(input cssa_word_t v);
        negate = cssa_word_t'(~v + 32'h00000001);
    endfunction : negate

    wire logic valid_op = (opcode >= `CSSA_OP_MAGSUB) &&
        (opcode <= `CSSA_OP_INVERSE_ZERO_STEERED_ACCUMULATE);
    wire logic take = start && (state_q == CSSA_IDLE) && valid_op;
    wire logic last = (state_q == CSSA_BUSY) && (cnt_q == `CSSA_CNT_LAST);

    wire cssa_word_t abs_s = s_q[`CSSA_W-1] ? negate(s_q) : s_q;
    wire logic [`CSSA_W:0] mag_diff = {1'b0, d_q} - {1'b0, abs_s};
    wire logic neg_sel = (op_q == `CSSA_OP_CARRY_STEERED_ACCUMULATE) ? c_q :
        (op_q == `CSSA_OP_INVERSE_CARRY_STEERED_ACCUMULATE) ? !c_q :
        (op_q == `CSSA_OP_ZERO_STEERED_ACCUMULATE) ? z_q : !z_q;
    wire cssa_word_t addend = neg_sel ? negate(s_q) : s_q;
    wire cssa_word_t sum = cssa_word_t'(d_q + addend);
    wire logic ovf = (d_q[`CSSA_W-1] == addend[`CSSA_W-1]) &&
        (sum[`CSSA_W-1] != d_q[`CSSA_W-1]);
    wire logic is_mag = (op_q == `CSSA_OP_MAGSUB);
    wire cssa_word_t res_w = is_mag ? mag_diff[`CSSA_W-1:0] : sum;
    wire logic carry_w = is_mag ? mag_diff[`CSSA_W] : ovf;

    always_comb begin
        state_d = state_q;
        case (state_q)
            CSSA_IDLE: begin
                if (take) begin
                    state_d = CSSA_BUSY;
                end
            end
            CSSA_BUSY: begin
                if (last) begin
                    state_d = CSSA_IDLE;
                end
            end
            default: state_d = CSSA_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= CSSA_IDLE;
            cnt_q <= `CSSA_CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= take ? `CSSA_CNT_ZERO :
                (state_q == CSSA_BUSY ? cnt_q + 2'h1 : cnt_q);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            op_q <= `CSSA_OP_MAGSUB;
            d_q <= `CSSA_ZERO32;
            s_q <= `CSSA_ZERO32;
            {z_q, c_q, wr_q, wz_q, wc_q, valid_op_q} <= 6'h00;
        end else if (take) begin
            op_q <= opcode;
            d_q <= dest_in;
            s_q <= src_in;
            {z_q, c_q, wr_q, wz_q, wc_q, valid_op_q} <=
                {zero_in, carry_in, wr_result, wr_zero, wr_carry, 1'b1};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy <= 1'b0;
            done <= 1'b0;
            result_we <= 1'b0;
            zero_we <= 1'b0;
            carry_we <= 1'b0;
            result <= `CSSA_ZERO32;
            zero_out <= 1'b0;
            carry_out <= 1'b0;
        end else begin
            busy <= take || ((state_q == CSSA_BUSY) && !last);
            done <= last;
            result_we <= last && wr_q;
            zero_we <= last && wz_q;
            carry_we <= last && wc_q;
            if (last) begin
                result <= res_w;
                zero_out <= wz_q ? (res_w == `CSSA_ZERO32) : z_q;
                carry_out <= wc_q ? carry_w : c_q;
            end
        end
    end

    property p_latency;
        @(posedge core_clk) disable iff (reset)
            take |-> ##4 done;
    endproperty
    a_latency: assert property (p_latency) else $error("done not at 4");

    sequence s_busy_run;
        busy [*3] ##1 (!busy && done);
    endsequence

    property p_busy_hold;
        @(posedge core_clk) disable iff (reset)
            take |=> s_busy_run;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy shape");

    property p_zero_flag;
        @(posedge core_clk) disable iff (reset)
            zero_we |-> zero_out == (result == `CSSA_ZERO32);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero wrong");

    property p_no_write;
        @(posedge core_clk) disable iff (reset)
            (take && !wr_result) |-> ##4 (done && !result_we);
    endproperty
    a_no_write: assert property (p_no_write) else $error("bad write");

    property p_carry_hold;
        @(posedge core_clk) disable iff (reset)
            (take && !wr_carry) |-> ##4 (carry_out == $past(carry_in, 4));
    endproperty
    a_carry_hold: assert property (p_carry_hold) else $error("carry moved");

    property p_inverse_carry_steered_accumulate;
        @(posedge core_clk) disable iff (reset)
            (take && opcode == `CSSA_OP_INVERSE_CARRY_STEERED_ACCUMULATE && carry_in) |-> ##4
            (result == cssa_word_t'($past(dest_in, 4) + $past(src_in, 4)));
    endproperty
    a_inverse_carry_steered_accumulate: assert property (p_inverse_carry_steered_accumulate) else $error("inverse_carry_steered_accumulate wrong");

    property p_inverse_zero_steered_accumulate;
        @(posedge core_clk) disable iff (reset)
            (take && opcode == `CSSA_OP_INVERSE_ZERO_STEERED_ACCUMULATE && !zero_in) |-> ##4
            (result == cssa_word_t'($past(dest_in, 4) - $past(src_in, 4)));
    endproperty
    a_inverse_zero_steered_accumulate: assert property (p_inverse_zero_steered_accumulate) else $error("inverse_zero_steered_accumulate wrong");

    property p_done_pulse;
        @(posedge core_clk) disable iff (reset)
            done |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done long");

    property p_we_with_done;
        @(posedge core_clk) disable iff (reset)
            (result_we || zero_we || carry_we) |-> done;
    endproperty
    a_we_with_done: assert property (p_we_with_done)
        else $error("stray write enable");

    sequence s_take_mag_pos;
        take && opcode == `CSSA_OP_MAGSUB && !src_in[31];
    endsequence

    property p_magsub;
        @(posedge core_clk) disable iff (reset)
            s_take_mag_pos |-> ##4
            (result == cssa_word_t'($past(dest_in, 4) - $past(src_in, 4)));
    endproperty
    a_magsub: assert property (p_magsub) else $error("magsub wrong");

    property p_carry_steered_accumulate;
        @(posedge core_clk) disable iff (reset)
            (take && opcode == `CSSA_OP_CARRY_STEERED_ACCUMULATE && !carry_in) |-> ##4
            (result == cssa_word_t'($past(dest_in, 4) + $past(src_in, 4)));
    endproperty
    a_carry_steered_accumulate: assert property (p_carry_steered_accumulate) else $error("carry_steered_accumulate wrong");

    property p_zero_steered_accumulate;
        @(posedge core_clk) disable iff (reset)
            (take && opcode == `CSSA_OP_ZERO_STEERED_ACCUMULATE && zero_in) |-> ##4
            (result == cssa_word_t'($past(dest_in, 4) - $past(src_in, 4)));
    endproperty
    a_zero_steered_accumulate: assert property (p_zero_steered_accumulate) else $error("zero_steered_accumulate wrong");

    property p_zero_hold;
        @(posedge core_clk) disable iff (reset)
            (take && !wr_zero) |-> ##4 (zero_out == $past(zero_in, 4));
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("zero moved");
endmodule : cssa_alu

// ### tb/cssa_decode_model.sv
// Decode stage model that issues slice instructions
module cssa_decode_model (
    input wire logic core_clk,
    output logic start,
    output cssa_pkg::cssa_op_t opcode,
    output cssa_pkg::cssa_word_t dest_in,
    output cssa_pkg::cssa_word_t src_in,
    output logic zero_in,
    output logic carry_in,
    output logic [2:0] wr_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import cssa_pkg::*;
    initial begin
        {start, opcode, dest_in, src_in, zero_in, carry_in, wr_en} = '0;
    end
    task send(cssa_op_t op, cssa_word_t d, s, logic z, c, logic [2:0] w);
        @(negedge core_clk);
        {start, opcode, dest_in, src_in} = {1'b1, op, d, s};
        {zero_in, carry_in, wr_en} = {z, c, w};
        @(posedge core_clk);
        @(negedge core_clk);
        {start, opcode, dest_in, src_in} = {1'b0, ~op, ~d, ~s};
        {zero_in, carry_in, wr_en} = {~z, ~c, ~w};
    endtask : send
endmodule : cssa_decode_model

// ### tb/tb_top.sv
// Self-checking bench for the signed sum slice
`include "cssa_defines.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cssa_pkg::*;
    logic core_clk = 0, reset = 1, start, zero_in, carry_in, busy, done;
    logic result_we, zero_we, carry_we, zero_out, carry_out;
    logic [2:0] wr_en;
    cssa_op_t opcode;
    cssa_word_t dest_in, src_in, result;
    int err_total = 0, checks = 0;
    always #2.5 core_clk = ~core_clk;
    cssa_decode_model PM (.core_clk(core_clk), .start(start),
        .opcode(opcode), .dest_in(dest_in), .src_in(src_in),
        .zero_in(zero_in), .carry_in(carry_in), .wr_en(wr_en));
    cssa_alu DUT (.core_clk(core_clk), .reset(reset), .start(start),
        .opcode(opcode), .dest_in(dest_in), .src_in(src_in),
        .zero_in(zero_in), .carry_in(carry_in), .wr_result(wr_en[2]),
        .wr_zero(wr_en[1]), .wr_carry(wr_en[0]), .busy(busy), .done(done),
        .result_we(result_we), .result(result), .zero_we(zero_we),
        .zero_out(zero_out), .carry_we(carry_we), .carry_out(carry_out));
    task tally_and_finish();
        $display("Checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    function automatic logic [33:0] model(cssa_op_t op, cssa_word_t d, s,
        logic z, c);
        cssa_word_t a, r;
        logic ng, ms;
        ms = op == `CSSA_OP_MAGSUB;
        ng = (op == `CSSA_OP_CARRY_STEERED_ACCUMULATE && c) || (op == `CSSA_OP_INVERSE_CARRY_STEERED_ACCUMULATE && !c) ||
            (op == `CSSA_OP_ZERO_STEERED_ACCUMULATE && z) || (op == `CSSA_OP_INVERSE_ZERO_STEERED_ACCUMULATE && !z);
        a = (ms ? s[31] : ng) ? -s : s;
        r = ms ? d - a : d + a;
        return {r, r == `CSSA_ZERO32,
            ms ? d < a : (d[31] == a[31] && r[31] != d[31])};
    endfunction : model
    task automatic run(cssa_op_t op, cssa_word_t d, s, logic z, c,
        logic [2:0] w);
        logic [33:0] e;
        int n;
        e = model(op, d, s, z, c);
        n = 1;
        PM.send(op, d, s, z, c, w);
        `CHK(busy, 1'b1)
        while (done !== 1'b1 && n < 9) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 9) begin
            err_total++;
            tally_and_finish();
        end
        `CHK(n, `CSSA_CYCLES)
        `CHK(busy, 1'b0)
        `CHK({result_we, zero_we, carry_we}, w)
        if (w[2]) `CHK(result, e[33:2])
        `CHK(zero_out, w[1] ? e[1] : z)
        `CHK(carry_out, w[0] ? e[0] : c)
    endtask : run
    task t_magsub();
        run(`CSSA_OP_MAGSUB, 32'hA, 32'hFFFFFFFD, 1'b1, 1'b1, 3'h7);
        run(`CSSA_OP_MAGSUB, 32'h2, 32'h5, 1'b1, 1'b0, 3'h7);
        run(`CSSA_OP_MAGSUB, 32'h5, 32'hFFFFFFFB, 1'b0, 1'b1, 3'h7);
    endtask : t_magsub
    task t_carry();
        for (int i = 0; i < 4; i++) begin
            run(i[1] ? `CSSA_OP_INVERSE_CARRY_STEERED_ACCUMULATE : `CSSA_OP_CARRY_STEERED_ACCUMULATE, 32'h7FFFFFF0,
                32'h10, 1'b0, i[0], 3'h7);
        end
        run(`CSSA_OP_CARRY_STEERED_ACCUMULATE, 32'h5, 32'h5, 1'b0, 1'b1, 3'h7);
    endtask : t_carry
    task t_zero();
        for (int i = 0; i < 4; i++) begin
            run(i[1] ? `CSSA_OP_INVERSE_ZERO_STEERED_ACCUMULATE : `CSSA_OP_ZERO_STEERED_ACCUMULATE, 32'h80000000,
                32'h1, i[0], 1'b0, 3'h7);
        end
    endtask : t_zero
    task t_enables();
        for (int i = 0; i < 8; i++) begin
            run(`CSSA_OP_INVERSE_ZERO_STEERED_ACCUMULATE, 32'h1, 32'h1, 1'b0, 1'b1, i[2:0]);
        end
    endtask : t_enables
    task t_refuse();
        int n;
        n = 0;
        PM.send(6'h22, 32'h3, 32'h1, 1'b0, 1'b0, 3'h7);
        repeat (6) begin
            @(negedge core_clk);
            n = n + (busy | done);
        end
        `CHK(n, 0)
        PM.send(`CSSA_OP_CARRY_STEERED_ACCUMULATE, 32'h3, 32'h1, 1'b0, 1'b0, 3'h7);
        PM.send(`CSSA_OP_ZERO_STEERED_ACCUMULATE, 32'h9, 32'h9, 1'b1, 1'b0, 3'h7);
        repeat (8) begin
            @(negedge core_clk);
            n = n + done;
        end
        `CHK(n, 1)
        `CHK(result, 32'h4)
    endtask : t_refuse
    task t_reset();
        PM.send(`CSSA_OP_CARRY_STEERED_ACCUMULATE, 32'h5, 32'h1, 1'b0, 1'b0, 3'h7);
        reset = 1;
        repeat (2) @(negedge core_clk);
        `CHK({busy, done, result_we, zero_we, carry_we}, 5'h0)
        `CHK({result, zero_out, carry_out}, 34'h0)
        reset = 0;
        run(`CSSA_OP_INVERSE_CARRY_STEERED_ACCUMULATE, 32'h5, 32'h1, 1'b0, 1'b1, 3'h7);
    endtask : t_reset
    initial begin
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        reset = 0;
        t_magsub();
        t_carry();
        t_zero();
        t_enables();
        t_refuse();
        t_reset();
        tally_and_finish();
    end
endmodule : tb_top
